// file: rtl/adc_seq_cfg.svh
`ifndef ADC_SEQ_CFG_SVH
`define ADC_SEQ_CFG_SVH

// ==========================================================================
// Register byte offsets on the AXI4-Lite slave.
// ==========================================================================
`define OFS_ACTIVE_HIGH 8'h00
`define OFS_ACTIVE_LOW 8'h04
`define OFS_RESULT 8'h08
`define OFS_IRQ_MASK 8'h0C
`define OFS_GEN_CONFIG 8'h14
`define OFS_GEN_STATUS 8'h18
`define OFS_RAW_IRQ 8'h1C
`define OFS_FIFO_STATUS 8'h20
`define OFS_HIGH_BANK 8'h24
`define OFS_LOW_BANK 8'h64
`define OFS_IDLE_HIGH 8'hA4
`define OFS_IDLE_LOW 8'hA8
`define OFS_MASKED_IRQ 8'hAC
`define OFS_IRQ_CLEAR 8'hB0

// ==========================================================================
// Field positions.
// ==========================================================================
`define GC_SSM_LSB 1
`define GC_SSB_BIT 0
`define GC_WMK_LSB 3
`define GC_NOC_LSB 7
`define GS_PEN_RAW_BIT 8
`define GS_BROWN_RAW_BIT 9
`define HW_SETTLE_LSB 7
`define IRQ_PEN_BIT 0
`define IRQ_EOS_BIT 1
`define IRQ_WMK_BIT 2
`define IRQ_OVR_BIT 3
`define IRQ_BROWN_BIT 4

// ==========================================================================
// Values and timing counts.
// ==========================================================================
`define SSM_CONTINUOUS 2'b11
`define SAR_MID_SCALE 10'h200
`define CONV_CYCLES 5'd17
`define FIFO_DEPTH 5'd16
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// file: rtl/adc_seq_pkg.sv
package adc_seq_pkg;

    // Sequencer states.
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_FETCH = 3'b001,
        ST_SETTLE = 3'b010,
        ST_CONVERT = 3'b011,
        ST_WAIT = 3'b100,
        ST_DONE = 3'b101
    } seq_state_t;

endpackage

// file: rtl/adc_measurement_sequencer.sv
// The AXI4-Lite register port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "adc_seq_cfg.svh"

module adc_measurement_sequencer
    import adc_seq_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    // AXI4-Lite slave.
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Analog side.
    input wire logic comparator_high,
    input wire logic pen_down_raw,
    input wire logic brownout_raw,
    output logic [15:0] active_high_word,
    output logic [15:0] active_low_word,
    output logic [9:0] sar_dac_word,
    output logic sample_hold,
    // Interrupts.
    output logic combined_panel_irq,
    output logic supply_low_irq
);

    // ======================================================================
    // State struct: everything the block remembers.
    // ======================================================================
    typedef struct packed {
        seq_state_t st;
        logic [15:0] ahw;
        logic [15:0] alw;
        logic [9:0] sar;
        logic [9:0] bitmask;
        logic [8:0] settle_cnt;
        logic [4:0] cyc_cnt;
        logic [3:0] step;
        logic [15:0] idle_hw;
        logic [15:0] idle_lw;
        logic [31:0] gcfg;
        logic [4:0] imask;
        logic [4:0] latched;
        logic pen_q;
        logic [15:0][15:0] fifo;
        logic [3:0] wr_ptr;
        logic [3:0] rd_ptr;
        logic [4:0] count;
        logic [15:0][15:0] hbank;
        logic [15:0][15:0] lbank;
        logic aw_got;
        logic w_got;
        logic [7:0] aw_addr;
        logic [31:0] w_data;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic comb_irq;
        logic brown_irq;
    } state_t;

    state_t cur_reg;
    state_t cur_next;

    // Decoded write access, evaluated once both halves have arrived.
    logic wr_fire;
    logic rd_fire;
    logic cont_mode;
    logic start_req;
    logic fifo_pop;
    logic [4:0] irq_raw;
    logic [7:0] rd_addr;

    // ======================================================================
    // Next-state logic.
    // ======================================================================
    always_comb begin
        cur_next = cur_reg;
        cont_mode = (cur_reg.gcfg[`GC_SSM_LSB +: 2] == `SSM_CONTINUOUS);
        start_req = cur_reg.latched[`IRQ_PEN_BIT] | cur_reg.gcfg[`GC_SSB_BIT];
        wr_fire = cur_reg.aw_got & cur_reg.w_got & ~cur_reg.bvalid;
        rd_fire = s_axi_arvalid & ~cur_reg.rvalid;
        rd_addr = s_axi_araddr;
        fifo_pop = rd_fire & (rd_addr == `OFS_RESULT) & (cur_reg.count != 5'd0);

        // Pen edge and brownout level set latched status; set beats clear.
        // Clears are applied first so a same-cycle event survives.
        if (wr_fire && cur_reg.aw_addr == `OFS_IRQ_CLEAR) begin
            if (cur_reg.w_data[`IRQ_PEN_BIT]) begin
                cur_next.latched[`IRQ_PEN_BIT] = 1'b0;
            end
            if (cur_reg.w_data[`IRQ_EOS_BIT]) begin
                cur_next.latched[`IRQ_EOS_BIT] = 1'b0;
            end
            if (cur_reg.w_data[`IRQ_BROWN_BIT]) begin
                cur_next.latched[`IRQ_BROWN_BIT] = 1'b0;
            end
        end
        cur_next.pen_q = pen_down_raw;
        if (pen_down_raw && !cur_reg.pen_q) begin
            cur_next.latched[`IRQ_PEN_BIT] = 1'b1;
        end
        // A brownout still present re-latches on the very next edge.
        if (brownout_raw) begin
            cur_next.latched[`IRQ_BROWN_BIT] = 1'b1;
        end
        // Reading the result register removes the oldest entry.
        if (fifo_pop) begin
            cur_next.rd_ptr = cur_reg.rd_ptr + 4'd1;
            cur_next.count = cur_reg.count - 5'd1;
            cur_next.latched[`IRQ_OVR_BIT] = 1'b0;
        end

        // Sequencer.
        case (cur_reg.st)
            ST_IDLE: begin
                cur_next.ahw = cur_reg.idle_hw;
                cur_next.alw = cur_reg.idle_lw;
                cur_next.step = 4'd0;
                if (cont_mode || start_req) begin
                    cur_next.st = ST_FETCH;
                    cur_next.gcfg[`GC_SSB_BIT] = 1'b0;
                end
            end
            ST_FETCH: begin
                // Bank entry becomes the active pair for this step.
                cur_next.ahw = cur_reg.hbank[cur_reg.step];
                cur_next.alw = cur_reg.lbank[cur_reg.step];
                cur_next.settle_cnt =
                    cur_reg.hbank[cur_reg.step][`HW_SETTLE_LSB +: 9];
                cur_next.st = ST_SETTLE;
            end
            ST_SETTLE: begin
                // Acquisition: sample-and-hold tracks during settling.
                if (cur_reg.settle_cnt <= 9'd1) begin
                    cur_next.sar = `SAR_MID_SCALE;
                    cur_next.bitmask = `SAR_MID_SCALE;
                    cur_next.cyc_cnt = 5'd0;
                    cur_next.st = ST_CONVERT;
                end else begin
                    cur_next.settle_cnt = cur_reg.settle_cnt - 9'd1;
                end
            end
            ST_CONVERT: begin
                // One decision per cycle for ten cycles; remaining cycles
                // pad the conversion to its fixed length.
                cur_next.cyc_cnt = cur_reg.cyc_cnt + 5'd1;
                if (cur_reg.bitmask != 10'h000) begin
                    cur_next.bitmask = cur_reg.bitmask >> 1;
                    cur_next.sar[9:0] = (comparator_high ? cur_reg.sar :
                        (cur_reg.sar & ~cur_reg.bitmask)) |
                        (cur_reg.bitmask >> 1);
                end
                if (cur_reg.cyc_cnt == `CONV_CYCLES - 5'd3) begin
                    cur_next.st = ST_WAIT;
                end
            end
            ST_WAIT: begin
                // End of conversion: store result and tag unless full.
                if (cur_reg.count == `FIFO_DEPTH && !fifo_pop) begin
                    cur_next.latched[`IRQ_OVR_BIT] = 1'b1;
                end else begin
                    cur_next.fifo[cur_reg.wr_ptr] =
                        {2'b00, cur_reg.step, cur_reg.sar};
                    cur_next.wr_ptr = cur_reg.wr_ptr + 4'd1;
                    cur_next.count = cur_next.count + 5'd1;
                end
                if (cur_reg.step == cur_reg.gcfg[`GC_NOC_LSB +: 4]) begin
                    cur_next.st = ST_DONE;
                end else begin
                    cur_next.step = cur_reg.step + 4'd1;
                    cur_next.st = ST_FETCH;
                end
            end
            ST_DONE: begin
                cur_next.latched[`IRQ_EOS_BIT] = 1'b1;
                cur_next.step = 4'd0;
                if (cont_mode) begin
                    cur_next.st = ST_FETCH;
                end else begin
                    cur_next.ahw = cur_reg.idle_hw;
                    cur_next.alw = cur_reg.idle_lw;
                    cur_next.st = ST_IDLE;
                end
            end
            default: begin
                cur_next.st = ST_IDLE;
            end
        endcase

        // Watermark is a level, not latched.
        cur_next.latched[`IRQ_WMK_BIT] = (cur_next.count >=
            {1'b0, cur_reg.gcfg[`GC_WMK_LSB +: 4]});

        // AXI4-Lite write channel capture, either order.
        if (s_axi_awvalid && !cur_reg.aw_got) begin
            cur_next.aw_got = 1'b1;
            cur_next.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !cur_reg.w_got) begin
            cur_next.w_got = 1'b1;
            cur_next.w_data = s_axi_wdata;
        end
        if (wr_fire) begin
            cur_next.aw_got = 1'b0;
            cur_next.w_got = 1'b0;
            cur_next.bvalid = 1'b1;
            cur_next.bresp = `RESP_OKAY;
            case (cur_reg.aw_addr)
                `OFS_IRQ_MASK: cur_next.imask = cur_reg.w_data[4:0];
                `OFS_GEN_CONFIG: cur_next.gcfg = cur_reg.w_data;
                `OFS_IDLE_HIGH: cur_next.idle_hw = cur_reg.w_data[15:0];
                `OFS_IDLE_LOW: cur_next.idle_lw = cur_reg.w_data[15:0];
                `OFS_ACTIVE_HIGH, `OFS_ACTIVE_LOW, `OFS_RESULT,
                `OFS_GEN_STATUS, `OFS_RAW_IRQ, `OFS_FIFO_STATUS,
                `OFS_MASKED_IRQ, `OFS_IRQ_CLEAR:
                    cur_next.bresp = `RESP_OKAY;
                default: begin
                    if (cur_reg.aw_addr >= `OFS_HIGH_BANK &&
                        cur_reg.aw_addr < `OFS_IDLE_HIGH &&
                        cur_reg.aw_addr[1:0] == 2'b00) begin
                        if (cur_reg.aw_addr < `OFS_LOW_BANK) begin
                            cur_next.hbank[4'((cur_reg.aw_addr -
                                `OFS_HIGH_BANK) >> 2)] =
                                cur_reg.w_data[15:0];
                        end else begin
                            cur_next.lbank[4'((cur_reg.aw_addr -
                                `OFS_LOW_BANK) >> 2)] =
                                cur_reg.w_data[15:0];
                        end
                    end else begin
                        cur_next.bresp = `RESP_SLVERR;
                    end
                end
            endcase
        end
        if (cur_reg.bvalid && s_axi_bready) begin
            cur_next.bvalid = 1'b0;
        end

        // AXI4-Lite read channel.
        if (rd_fire) begin
            cur_next.rvalid = 1'b1;
            cur_next.rresp = `RESP_OKAY;
            cur_next.rdata = 32'h0000_0000;
            case (rd_addr)
                `OFS_ACTIVE_HIGH: cur_next.rdata[15:0] = cur_reg.ahw;
                `OFS_ACTIVE_LOW: cur_next.rdata[15:0] = cur_reg.alw;
                `OFS_RESULT: cur_next.rdata[15:0] = cur_reg.fifo[cur_reg.rd_ptr];
                `OFS_IRQ_MASK: cur_next.rdata[4:0] = cur_reg.imask;
                `OFS_GEN_CONFIG: cur_next.rdata = cur_reg.gcfg;
                `OFS_GEN_STATUS: begin
                    cur_next.rdata[`GS_PEN_RAW_BIT] = pen_down_raw;
                    cur_next.rdata[`GS_BROWN_RAW_BIT] = brownout_raw;
                    cur_next.rdata[2:0] = cur_reg.st;
                end
                `OFS_RAW_IRQ: cur_next.rdata[4:0] = cur_reg.latched;
                `OFS_FIFO_STATUS: cur_next.rdata[4:0] = cur_reg.count;
                `OFS_IDLE_HIGH: cur_next.rdata[15:0] = cur_reg.idle_hw;
                `OFS_IDLE_LOW: cur_next.rdata[15:0] = cur_reg.idle_lw;
                `OFS_MASKED_IRQ:
                    cur_next.rdata[4:0] = cur_reg.latched & cur_reg.imask;
                `OFS_IRQ_CLEAR: cur_next.rdata = 32'h0000_0000;
                default: begin
                    if (rd_addr >= `OFS_HIGH_BANK && rd_addr < `OFS_LOW_BANK
                        && rd_addr[1:0] == 2'b00) begin
                        cur_next.rdata[15:0] = cur_reg.hbank[
                            4'((rd_addr - `OFS_HIGH_BANK) >> 2)];
                    end else if (rd_addr >= `OFS_LOW_BANK &&
                        rd_addr < `OFS_IDLE_HIGH && rd_addr[1:0] == 2'b00) begin
                        cur_next.rdata[15:0] = cur_reg.lbank[
                            4'((rd_addr - `OFS_LOW_BANK) >> 2)];
                    end else begin
                        cur_next.rresp = `RESP_SLVERR;
                    end
                end
            endcase
        end
        if (cur_reg.rvalid && s_axi_rready) begin
            cur_next.rvalid = 1'b0;
        end

        // Masks gate only the outputs; latched bits are untouched.
        irq_raw = cur_next.latched & cur_next.imask;
        cur_next.comb_irq = |irq_raw[3:0];
        cur_next.brown_irq = irq_raw[`IRQ_BROWN_BIT];
    end

    // ======================================================================
    // State register.
    // ======================================================================
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cur_reg <= '0;
        end else begin
            cur_reg <= cur_next;
        end
    end

    // ======================================================================
    // Outputs, all straight from the state register.
    // ======================================================================
    assign s_axi_awready = ~cur_reg.aw_got;
    assign s_axi_wready = ~cur_reg.w_got;
    assign s_axi_bvalid = cur_reg.bvalid;
    assign s_axi_bresp = cur_reg.bresp;
    assign s_axi_arready = ~cur_reg.rvalid;
    assign s_axi_rvalid = cur_reg.rvalid;
    assign s_axi_rdata = cur_reg.rdata;
    assign s_axi_rresp = cur_reg.rresp;
    assign active_high_word = cur_reg.ahw;
    assign active_low_word = cur_reg.alw;
    assign sar_dac_word = cur_reg.sar;
    assign sample_hold = (cur_reg.st == ST_CONVERT);
    assign combined_panel_irq = cur_reg.comb_irq;
    assign supply_low_irq = cur_reg.brown_irq;

endmodule

// file: verification/adc_analog_model.sv
`timescale 1ns/1ps

// =====================================================================
// Converter front end: comparator against the internal DAC word.
// =====================================================================
module adc_analog_model (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [9:0] sar_dac_word,
    input wire logic sample_hold,
    input wire logic [15:0] active_low_word,
    output logic comparator_high
);
    // Free toggling level seen while nothing is held.
    logic wander_reg;

    // The comparator is only meaningful during hold, so it wanders outside.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wander_reg <= 1'b0;
        end else begin
            wander_reg <= ~wander_reg;
        end
    end

    // Held input sits half a step above the low word's code.
    assign comparator_high = sample_hold ?
        (sar_dac_word <= active_low_word[9:0]) : wander_reg;
endmodule

// file: verification/adc_measurement_sequencer_monitor.sv
`timescale 1ns/1ps
`include "adc_seq_cfg.svh"

// =====================================================================
// Port checker for the measurement sequencer.
// =====================================================================
module adc_measurement_sequencer_monitor (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [9:0] sar_dac_word,
    input wire logic sample_hold,
    input wire logic [15:0] active_high_word,
    input wire logic [15:0] active_low_word,
    input wire logic combined_panel_irq,
    input wire logic supply_low_irq
);
    // Length of the current hold.
    logic [4:0] hold_len_reg;
    // Cycles since any bus activity, saturating.
    logic [3:0] bus_age_reg;
    // Mid-scale has been driven since the last hold ended.
    logic seen_mid_reg;

    // Helper counters; the saturation keeps old activity from aliasing.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            hold_len_reg <= 5'h00;
            bus_age_reg <= 4'hF;
            seen_mid_reg <= 1'b0;
        end else begin
            hold_len_reg <= sample_hold ? hold_len_reg + 5'h01 : 5'h00;
            if (s_axi_awvalid || s_axi_arvalid || s_axi_bvalid
                || s_axi_rvalid) begin
                bus_age_reg <= 4'h0;
            end else if (bus_age_reg != 4'hF) begin
                bus_age_reg <= bus_age_reg + 4'h1;
            end
            if (sar_dac_word == `SAR_MID_SCALE) begin
                seen_mid_reg <= 1'b1;
            end else if ($fell(sample_hold)) begin
                seen_mid_reg <= 1'b0;
            end
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    mid_scale_a: assert property ($fell(sample_hold) |-> seen_mid_reg)
        else $error("no mid-scale start");
    result_hold_a: assert property (
        $fell(sample_hold) |=> $stable(sar_dac_word))
        else $error("finished word not held");
    hold_min_a: assert property (
        $rose(sample_hold) |-> sample_hold [*8])
        else $error("conversion cut short");
    hold_len_a: assert property (hold_len_reg <= `CONV_CYCLES)
        else $error("conversion too long");
    hold_gap_a: assert property (
        $fell(sample_hold) |=> !sample_hold)
        else $error("conversions overlap");
    words_stable_a: assert property (
        sample_hold && $past(sample_hold) |->
        $stable(active_high_word) && $stable(active_low_word))
        else $error("active words moved");
    brown_latch_a: assert property (
        $fell(supply_low_irq) |-> bus_age_reg <= 4'h4)
        else $error("brownout dropped unasked");
    panel_latch_a: assert property (
        $fell(combined_panel_irq) |-> bus_age_reg <= 4'h4)
        else $error("panel irq dropped unasked");
    wresp_once_a: assert property (
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answered twice");
    rresp_once_a: assert property (
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answered twice");

    cover property ($rose(sample_hold));
    cover property ($fell(supply_low_irq));
    cover property ($fell(combined_panel_irq));
endmodule

bind adc_measurement_sequencer adc_measurement_sequencer_monitor
    u_adc_measurement_sequencer_monitor (.*);

// file: verification/adc_measurement_sequencer_tb.sv
`timescale 1ns/1ps
`include "adc_seq_cfg.svh"

// =====================================================================
// Bench for the measurement sequencer.
// =====================================================================
module adc_measurement_sequencer_tb;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, sample_hold, combined_panel_irq, supply_low_irq;
    logic [1:0] s_axi_bresp, s_axi_rresp, wr_resp, rd_resp;
    logic pen_down_raw = 1'b0, brownout_raw = 1'b0, comparator_high;
    logic [15:0] active_high_word, active_low_word;
    logic [9:0] sar_dac_word;
    logic [31:0] rd_data;
    // Step inputs: both ends of the scale and an alternating code.
    logic [9:0] codes [3] = '{10'h3FF, 10'h000, 10'h155};
    int n_mismatch = 0, cmp_count = 0, cyc = 0, last_rise = 0;
    int period = 0, n_conv = 0;
    logic sh_q = 1'b0;

    adc_measurement_sequencer u_adc_measurement_sequencer (.*);
    adc_analog_model u_adc_analog_model (.*);

    initial begin
        forever #2 ref_clk = ~ref_clk;
    end

    // Counts holds and the spacing between their starts.
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        sh_q <= sample_hold;
        if (sample_hold === 1'b1 && sh_q === 1'b0) begin
            n_conv <= n_conv + 1;
            period <= cyc - last_rise;
            last_rise <= cyc;
        end
    end

    // =================================================================
    // Shared tasks.
    // =================================================================
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time,
                seen, exp);
        end
    endtask

    task automatic give_up;
        n_mismatch++;
        $display("wait limit used up at %0t", $time);
        end_of_test();
    endtask

    // Each channel is released at the edge where its ready is seen.
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && n < 100);
        wr_resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (s_axi_bvalid !== 1'b1) give_up();
    endtask

    task automatic bus_rd(input logic [7:0] a);
        int n = 0;
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && n < 100);
        rd_data = s_axi_rdata;
        rd_resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (s_axi_rvalid !== 1'b1) give_up();
    endtask

    // Polls a register until the masked bits match.
    task automatic wait_val(input logic [7:0] a, input logic [31:0] m,
        input logic [31:0] v);
        int n = 0;
        do begin
            bus_rd(a);
            n++;
        end while ((rd_data & m) !== v && n < 300);
        if ((rd_data & m) !== v) give_up();
    endtask

    // =================================================================
    // Scenarios.
    // =================================================================
    task automatic t_reset;
        bus_rd(8'h0C);
        chk(rd_data, 32'h0000_0000);
        bus_rd(8'h20);
        chk(rd_data, 32'h0000_0000);
        bus_rd(8'hFC);
        chk(32'(rd_resp), 32'(`RESP_SLVERR));
        bus_wr(8'h10, 32'h0000_FFFF);
        chk(32'(wr_resp), 32'(`RESP_SLVERR));
    endtask

    // Three steps, settling of two cycles each, one-shot start.
    task automatic t_single;
        int c0;
        for (int i = 0; i < 3; i++) begin
            bus_wr(8'(8'h24 + 4 * i), 32'h0000_0100 | 32'(i));
            bus_wr(8'(8'h64 + 4 * i), 32'(codes[i]));
        end
        bus_wr(8'hA4, 32'h0000_0A5A);
        bus_wr(8'hA8, 32'h0000_05A5);
        c0 = n_conv;
        bus_wr(8'h14, 32'h0000_0119);
        wait_val(8'h1C, 32'h0000_0002, 32'h0000_0002);
        chk(32'(n_conv - c0), 32'h0000_0003);
        chk(32'(period), 32'h0000_0013);
        bus_rd(8'h1C);
        chk(32'(rd_data[4:0]), 32'h0000_0006);
        for (int i = 0; i < 3; i++) begin
            bus_rd(8'h08);
            chk(32'(rd_data[13:0]), 32'({i[3:0], codes[i]}));
        end
        bus_rd(8'h1C);
        chk(32'(rd_data[4:0]), 32'h0000_0002);
        bus_rd(8'h00);
        chk(rd_data, 32'h0000_0A5A);
        bus_rd(8'h04);
        chk(rd_data, 32'h0000_05A5);
        bus_rd(8'h18);
        chk(32'(rd_data[2:0]), 32'h0000_0000);
        bus_wr(8'hB0, 32'h0000_0002);
        bus_rd(8'h1C);
        chk(32'(rd_data[1]), 32'h0000_0000);
    endtask

    // Continuous running until the FIFO overruns, then a full drain.
    task automatic t_continuous;
        bus_wr(8'h14, 32'h0000_007E);
        wait_val(8'h1C, 32'h0000_0008, 32'h0000_0008);
        bus_rd(8'h18);
        chk(32'(rd_data[2:0] != 3'h0), 32'h0000_0001);
        bus_rd(8'h20);
        chk(rd_data, 32'h0000_0010);
        bus_wr(8'h14, 32'h0000_0078);
        wait_val(8'h18, 32'h0000_0007, 32'h0000_0000);
        bus_rd(8'h08);
        chk(32'(rd_data[13:0]), 32'h0000_03FF);
        bus_rd(8'h1C);
        chk(32'(rd_data[3:2]), 32'h0000_0001);
        bus_rd(8'h08);
        bus_rd(8'h1C);
        chk(32'(rd_data[2]), 32'h0000_0000);
        repeat (14) bus_rd(8'h08);
        bus_rd(8'h20);
        chk(rd_data, 32'h0000_0000);
    endtask

    // Pen trigger, masking and clearing of the latched pen event.
    task automatic t_pen;
        bus_wr(8'hB0, 32'h0000_0013);
        bus_wr(8'h0C, 32'h0000_0001);
        pen_down_raw <= 1'b1;
        wait_val(8'h1C, 32'h0000_0001, 32'h0000_0001);
        bus_rd(8'h18);
        chk(32'(rd_data[8]), 32'h0000_0001);
        chk(32'(combined_panel_irq), 32'h0000_0001);
        bus_wr(8'h0C, 32'h0000_0000);
        repeat (2) @(posedge ref_clk);
        chk(32'(combined_panel_irq), 32'h0000_0000);
        bus_rd(8'h1C);
        chk(32'(rd_data[0]), 32'h0000_0001);
        pen_down_raw <= 1'b0;
        bus_wr(8'hB0, 32'h0000_0001);
        bus_rd(8'h18);
        chk(32'(rd_data[8]), 32'h0000_0000);
        bus_rd(8'h1C);
        chk(32'(rd_data[0]), 32'h0000_0000);
        wait_val(8'h18, 32'h0000_0007, 32'h0000_0000);
        bus_rd(8'h20);
        chk(32'(rd_data != 32'h0000_0000), 32'h0000_0001);
    endtask

    // Brownout: raw level, latch, own output, clear and quick re-set.
    task automatic t_brown;
        bus_wr(8'h0C, 32'h0000_0010);
        brownout_raw <= 1'b1;
        repeat (3) @(posedge ref_clk);
        bus_rd(8'h18);
        chk(32'(rd_data[9]), 32'h0000_0001);
        brownout_raw <= 1'b0;
        repeat (3) @(posedge ref_clk);
        bus_rd(8'h18);
        chk(32'(rd_data[9]), 32'h0000_0000);
        bus_rd(8'h1C);
        chk(32'(rd_data[4]), 32'h0000_0001);
        chk(32'(supply_low_irq), 32'h0000_0001);
        chk(32'(combined_panel_irq), 32'h0000_0000);
        bus_wr(8'h0C, 32'h0000_0000);
        repeat (2) @(posedge ref_clk);
        chk(32'(supply_low_irq), 32'h0000_0000);
        bus_wr(8'hB0, 32'h0000_0010);
        bus_rd(8'h1C);
        chk(32'(rd_data[4]), 32'h0000_0000);
        brownout_raw <= 1'b1;
        @(posedge ref_clk);
        brownout_raw <= 1'b0;
        repeat (3) @(posedge ref_clk);
        bus_rd(8'h1C);
        chk(32'(rd_data[4]), 32'h0000_0001);
    endtask

    // Reset is held, then the scenarios run in turn.
    initial begin
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        t_reset();
        t_single();
        t_continuous();
        t_pen();
        t_brown();
        end_of_test();
    end
endmodule
